// ===== logic/video_output_control_map.vh
// Register offsets, field positions and reset values of the video output control bank
`ifndef VIDEO_OUTPUT_CONTROL_MAP_VH
`define VIDEO_OUTPUT_CONTROL_MAP_VH
`define ADDR_OUTPUT_PIN_MODE        8'h25
`define ADDR_POWER_THREE_STATE      8'h26
`define ADDR_AUTO_LOW_POWER         8'h27
`define ADDR_LINE_DELAY             8'h28
`define ADDR_PIXEL_DELAY_LOWER      8'h29
`define ADDR_WIDTH_UPPER            8'h2a
`define ADDR_WIDTH_LOWER            8'h2b
`define ADDR_HEIGHT_UPPER           8'h2c
`define ADDR_HEIGHT_LOWER           8'h2d
`define ADDR_TEST                   8'h2e
`define ADDR_LINK_STATUS            8'h2f
`define RST_OUTPUT_PIN_MODE         8'h02
`define RST_POWER_THREE_STATE       8'h08
`define RST_AUTO_LOW_POWER          8'h80
`define RST_LINE_DELAY              8'h01
`define RST_PIXEL_DELAY_LOWER       8'h04
`define RST_WIDTH_UPPER             8'h05
`define RST_WIDTH_LOWER             8'h00
`define RST_HEIGHT_UPPER            8'h02
`define RST_HEIGHT_LOWER            8'hd0
`define RST_TEST                    8'h00
`define MASK_OUTPUT_PIN_MODE        8'h0f
`define MASK_POWER_THREE_STATE      8'hcf
`define MASK_AUTO_LOW_POWER         8'hff
`define MASK_LINE_DELAY             8'hff
`define MASK_UPPER_NIBBLE           8'h0f
`define MASK_FULL                   8'hff
`define MASK_TEST                   8'h80
`define BIT_SECONDARY_EN            0
`define BIT_PRIMARY_EN              1
`define POS_OUT_MODE_LO             2
`define POS_OUT_MODE_HI             3
`define BIT_POWER_DOWN              0
`define POS_PD_FUNC_LO              1
`define POS_PD_FUNC_HI              2
`define BIT_PD_POLARITY             3
`define BIT_GREEN_SYNC_TRISTATE     6
`define BIT_OUTPUT_TRISTATE         7
`define BIT_AUTO_LOW_POWER          7
`define BIT_PROTECT_ADDR_LSB        6
`define BIT_MCLK_EXTERNAL           5
`define BIT_TIMING_CODE_EN          4
`define BIT_FORCE_ENABLE_GEN        3
`define POS_INTERLACE_LO            0
`define POS_INTERLACE_HI            2
`define POS_VDELAY_LO               2
`define POS_VDELAY_HI               7
`define POS_HDELAY_UP_LO            0
`define POS_HDELAY_UP_HI            1
`define BIT_STAT_ENABLE_DETECT      6
`define BIT_STAT_CLOCK_DETECT       5
`define BIT_STAT_KEY_LOAD_OK        3
`define BIT_TEST_REQUIRED           7
`define MODE_FULL_CHROMA            2'h0
`define MODE_HALF_PLUS_DDR          2'h1
`define MODE_DDR_FULL_PLUS_DDR      2'h2
`define PDF_POWER_DOWN              2'h0
`define PDF_POWER_DOWN_GREEN        2'h1
`define PDF_TRISTATE_OUT            2'h2
`define PDF_TRISTATE_BOTH           2'h3
`define QUALITY_WINDOW              8'hff
`define QUALITY_MAX                 3'h7
`endif

// ===== logic/pin_sync.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             clock_en,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   // First stage feeds only the second
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else if (clock_en) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== logic/video_output_control_regs.v
// Video output control and link status register bank
`timescale 1ns/10ps
`default_nettype none
`include "video_output_control_map.vh"
module video_output_control_regs (
   input  wire        clock,
   input  wire        rst,
   input  wire        clock_en,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   input  wire        power_down_pin,
   input  wire        link_enable_in,
   input  wire        link_clock_seen,
   input  wire        key_load_done,
   input  wire        key_load_pass,
   input  wire        enable_polarity,
   input  wire        idle_detect,
   output reg  [1:0]  out_pin_mode,
   output reg         primary_drive,
   output reg         secondary_drive,
   output reg         data_out_tristate,
   output reg         green_channel_sync_tristate,
   output reg         power_down_active,
   output reg         low_power_active,
   output reg         protect_port_addr_lsb,
   output reg         mclk_external_sel,
   output reg         embedded_timing_code_enable,
   output reg         force_internal_enable_gen,
   output reg         use_internal_enable,
   output reg         data_enable_out,
   output reg  [2:0]  interlace_offset,
   output reg  [5:0]  vertical_start_delay,
   output reg  [9:0]  horizontal_start_delay,
   output reg  [11:0] active_width,
   output reg  [11:0] active_height,
   output reg         test_bit_ok
);
   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   wire [4:0] pins_s;
   wire       pd_pin_s;
   wire       enable_s;
   wire       clk_seen_s;
   wire       key_done_s;
   wire       key_pass_s;
   pin_sync #(
      .WIDTH(5)
   ) u_pin_sync (
      .clock    (clock),
      .rst      (rst),
      .clock_en (clock_en),
      .async_in ({power_down_pin, link_enable_in, link_clock_seen,
                  key_load_done, key_load_pass}),
      .sync_out (pins_s)
   );
   assign pd_pin_s   = pins_s[4];
   assign enable_s   = pins_s[3];
   assign clk_seen_s = pins_s[2];
   assign key_done_s = pins_s[1];
   assign key_pass_s = pins_s[0];

   // ****************************************************
   // Writable registers
   // ****************************************************
   reg [7:0] out_mode_q;
   reg [7:0] power_q;
   reg [7:0] auto_q;
   reg [7:0] line_delay_q;
   reg [7:0] pix_lower_q;
   reg [7:0] width_up_q;
   reg [7:0] width_lo_q;
   reg [7:0] height_up_q;
   reg [7:0] height_lo_q;
   reg [7:0] test_q;
   reg       key_ok_q;
   reg       enable_d1_q;
   reg [7:0] edge_count_q;
   reg [7:0] window_q;
   reg [2:0] quality_q;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         out_mode_q   <= `RST_OUTPUT_PIN_MODE;
         power_q      <= `RST_POWER_THREE_STATE;
         auto_q       <= `RST_AUTO_LOW_POWER;
         line_delay_q <= `RST_LINE_DELAY;
         pix_lower_q  <= `RST_PIXEL_DELAY_LOWER;
         width_up_q   <= `RST_WIDTH_UPPER;
         width_lo_q   <= `RST_WIDTH_LOWER;
         height_up_q  <= `RST_HEIGHT_UPPER;
         height_lo_q  <= `RST_HEIGHT_LOWER;
         test_q       <= `RST_TEST;
      end else if (clock_en && reg_wr) begin
         case (reg_addr)
            `ADDR_OUTPUT_PIN_MODE:   out_mode_q   <= reg_wdata & `MASK_OUTPUT_PIN_MODE;
            `ADDR_POWER_THREE_STATE: power_q      <= reg_wdata & `MASK_POWER_THREE_STATE;
            `ADDR_AUTO_LOW_POWER:    auto_q       <= reg_wdata & `MASK_AUTO_LOW_POWER;
            `ADDR_LINE_DELAY:        line_delay_q <= reg_wdata & `MASK_LINE_DELAY;
            `ADDR_PIXEL_DELAY_LOWER: pix_lower_q  <= reg_wdata & `MASK_FULL;
            `ADDR_WIDTH_UPPER:       width_up_q   <= reg_wdata & `MASK_UPPER_NIBBLE;
            `ADDR_WIDTH_LOWER:       width_lo_q   <= reg_wdata & `MASK_FULL;
            `ADDR_HEIGHT_UPPER:      height_up_q  <= reg_wdata & `MASK_UPPER_NIBBLE;
            `ADDR_HEIGHT_LOWER:      height_lo_q  <= reg_wdata & `MASK_FULL;
            `ADDR_TEST:              test_q       <= reg_wdata & `MASK_TEST;
            // Status writes fall here and are dropped
            default: ;
         endcase
      end
   end

   // ****************************************************
   // Link status sensing
   // ****************************************************
   // Quality counts enable edges over a fixed window, saturated to three bits
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         key_ok_q     <= 1'b0;
         enable_d1_q  <= 1'b0;
         edge_count_q <= 8'h00;
         window_q     <= 8'h00;
         quality_q    <= 3'h0;
      end else if (clock_en) begin
         if (key_done_s)
            key_ok_q <= key_pass_s;
         enable_d1_q <= enable_s;
         if (window_q == `QUALITY_WINDOW) begin
            window_q     <= 8'h00;
            edge_count_q <= 8'h00;
            quality_q    <= (edge_count_q > {5'h00, `QUALITY_MAX}) ?
                            `QUALITY_MAX : edge_count_q[2:0];
         end else begin
            window_q <= window_q + 8'h01;
            if ((enable_s != enable_d1_q) && (edge_count_q != `QUALITY_WINDOW))
               edge_count_q <= edge_count_q + 8'h01;
         end
      end
   end

   // ****************************************************
   // Read path
   // ****************************************************
   reg [7:0] rdata_d;
   always @* begin
      case (reg_addr)
         `ADDR_OUTPUT_PIN_MODE:   rdata_d = out_mode_q;
         `ADDR_POWER_THREE_STATE: rdata_d = power_q;
         `ADDR_AUTO_LOW_POWER:    rdata_d = auto_q;
         `ADDR_LINE_DELAY:        rdata_d = line_delay_q;
         `ADDR_PIXEL_DELAY_LOWER: rdata_d = pix_lower_q;
         `ADDR_WIDTH_UPPER:       rdata_d = width_up_q;
         `ADDR_WIDTH_LOWER:       rdata_d = width_lo_q;
         `ADDR_HEIGHT_UPPER:      rdata_d = height_up_q;
         `ADDR_HEIGHT_LOWER:      rdata_d = height_lo_q;
         `ADDR_TEST:              rdata_d = test_q;
         `ADDR_LINK_STATUS:       rdata_d = {1'b0, enable_s, clk_seen_s, 1'b0,
                                             key_ok_q, quality_q};
         default:                 rdata_d = 8'h00;
      endcase
   end

   // ****************************************************
   // Decoded controls
   // ****************************************************
   wire       pd_asserted = power_q[`BIT_PD_POLARITY] ? pd_pin_s : ~pd_pin_s;
   wire [1:0] pd_func     = power_q[`POS_PD_FUNC_HI:`POS_PD_FUNC_LO];
   wire [1:0] mode_sel    = out_mode_q[`POS_OUT_MODE_HI:`POS_OUT_MODE_LO];
   reg        pin_down_d;
   reg        pin_out_ts_d;
   reg        pin_green_ts_d;
   always @* begin
      pin_down_d     = 1'b0;
      pin_out_ts_d   = 1'b0;
      pin_green_ts_d = 1'b0;
      if (pd_asserted) begin
         case (pd_func)
            `PDF_POWER_DOWN:       pin_down_d = 1'b1;
            `PDF_POWER_DOWN_GREEN: begin
               pin_down_d     = 1'b1;
               pin_green_ts_d = 1'b1;
            end
            `PDF_TRISTATE_OUT:     pin_out_ts_d = 1'b1;
            `PDF_TRISTATE_BOTH: begin
               pin_out_ts_d   = 1'b1;
               pin_green_ts_d = 1'b1;
            end
            default:               pin_down_d = 1'b0;
         endcase
      end
   end

   // Secondary output exists only in the double-rate modes
   wire secondary_mode = (mode_sel == `MODE_HALF_PLUS_DDR) ||
                         (mode_sel == `MODE_DDR_FULL_PLUS_DDR);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata                   <= 8'h00;
         out_pin_mode                <= `MODE_FULL_CHROMA;
         primary_drive               <= 1'b0;
         secondary_drive             <= 1'b0;
         data_out_tristate           <= 1'b0;
         green_channel_sync_tristate <= 1'b0;
         power_down_active           <= 1'b0;
         low_power_active            <= 1'b0;
         protect_port_addr_lsb       <= 1'b0;
         mclk_external_sel           <= 1'b0;
         embedded_timing_code_enable <= 1'b0;
         force_internal_enable_gen   <= 1'b0;
         use_internal_enable         <= 1'b0;
         data_enable_out             <= 1'b0;
         interlace_offset            <= 3'h0;
         vertical_start_delay        <= 6'h00;
         horizontal_start_delay      <= 10'h000;
         active_width                <= 12'h000;
         active_height               <= 12'h000;
         test_bit_ok                 <= 1'b0;
      end else if (clock_en) begin
         if (reg_rd)
            reg_rdata <= rdata_d;
         out_pin_mode      <= mode_sel;
         data_out_tristate <= power_q[`BIT_OUTPUT_TRISTATE] | pin_out_ts_d;
         green_channel_sync_tristate <= power_q[`BIT_GREEN_SYNC_TRISTATE] |
                                        pin_green_ts_d;
         primary_drive     <= out_mode_q[`BIT_PRIMARY_EN] &
                              ~(power_q[`BIT_OUTPUT_TRISTATE] | pin_out_ts_d);
         secondary_drive   <= out_mode_q[`BIT_SECONDARY_EN] & secondary_mode &
                              ~(power_q[`BIT_OUTPUT_TRISTATE] | pin_out_ts_d);
         power_down_active <= power_q[`BIT_POWER_DOWN] | pin_down_d;
         low_power_active  <= auto_q[`BIT_AUTO_LOW_POWER] & idle_detect;
         protect_port_addr_lsb <= auto_q[`BIT_PROTECT_ADDR_LSB];
         mclk_external_sel <= auto_q[`BIT_MCLK_EXTERNAL];
         embedded_timing_code_enable <= auto_q[`BIT_TIMING_CODE_EN];
         force_internal_enable_gen   <= auto_q[`BIT_FORCE_ENABLE_GEN];
         use_internal_enable <= auto_q[`BIT_FORCE_ENABLE_GEN] & clk_seen_s;
         // Low polarity inverts the sensed link enable
         data_enable_out   <= enable_polarity ? enable_s : ~enable_s;
         interlace_offset  <= auto_q[`POS_INTERLACE_HI:`POS_INTERLACE_LO];
         vertical_start_delay <= line_delay_q[`POS_VDELAY_HI:`POS_VDELAY_LO];
         horizontal_start_delay <= {line_delay_q[`POS_HDELAY_UP_HI:`POS_HDELAY_UP_LO],
                                    pix_lower_q};
         active_width      <= {width_up_q[3:0], width_lo_q};
         active_height     <= {height_up_q[3:0], height_lo_q};
         test_bit_ok       <= test_q[`BIT_TEST_REQUIRED];
      end
   end
endmodule
`default_nettype wire

// ===== verif/video_output_control_regs_chk.sv
// Assertion checker for the video output control register bank
`timescale 1ns/10ps
`default_nettype none
module video_output_control_regs_chk (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        clock_en,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        link_enable_in,
   input wire logic        link_clock_seen,
   input wire logic        enable_polarity,
   input wire logic        idle_detect,
   input wire logic [1:0]  out_pin_mode,
   input wire logic        primary_drive,
   input wire logic        secondary_drive,
   input wire logic        data_out_tristate,
   input wire logic        low_power_active,
   input wire logic        data_enable_out,
   input wire logic [9:0]  horizontal_start_delay,
   input wire logic [11:0] active_width,
   input wire logic [11:0] active_height
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_width_low_load:
   assert property (clock_en && reg_wr && reg_addr == 8'h2b ##1 clock_en [*2]
      |-> active_width[7:0] == $past(reg_wdata, 2)) else $error("width byte lost");
   a_height_low_load:
   assert property (clock_en && reg_wr && reg_addr == 8'h2d ##1 clock_en [*2]
      |-> active_height[7:0] == $past(reg_wdata, 2)) else $error("height byte lost");
   a_pixel_low_load:
   assert property (clock_en && reg_wr && reg_addr == 8'h29 ##1 clock_en [*2]
      |-> horizontal_start_delay[7:0] == $past(reg_wdata, 2)) else $error("delay lost");
   a_primary_gated:
   assert property (primary_drive |-> !data_out_tristate) else $error("primary drives");
   a_secondary_mode:
   assert property (secondary_drive |-> !data_out_tristate
      && (out_pin_mode == 2'h1 || out_pin_mode == 2'h2)) else $error("secondary drives");
   a_low_power_idle:
   assert property (low_power_active && $past(clock_en) |-> $past(idle_detect))
      else $error("low power while busy");
   a_reserved_reads:
   assert property (clock_en && reg_rd && (reg_addr == 8'h2e || reg_addr > 8'h2f)
      |=> reg_rdata[6:0] == 7'h00) else $error("reserved bits set");
   a_enable_polarity:
   assert property (($stable(link_enable_in) && $stable(enable_polarity)) [*5]
      |-> data_enable_out == (link_enable_in ~^ enable_polarity)) else $error("enable level");
   a_clock_status:
   assert property ($stable(link_clock_seen) [*5] ##0 (clock_en && reg_rd && reg_addr == 8'h2f)
      |=> reg_rdata[5] == $past(link_clock_seen)) else $error("clock status wrong");
   a_enable_status:
   assert property ($stable(link_enable_in) [*5] ##0 (clock_en && reg_rd && reg_addr == 8'h2f)
      |=> reg_rdata[6] == $past(link_enable_in)) else $error("enable status wrong");
endmodule
bind video_output_control_regs video_output_control_regs_chk chk (.clock, .rst, .clock_en,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .link_enable_in, .link_clock_seen,
   .enable_polarity, .idle_detect, .out_pin_mode, .primary_drive, .secondary_drive,
   .data_out_tristate, .low_power_active, .data_enable_out, .horizontal_start_delay,
   .active_width, .active_height);
`default_nettype wire

// ===== verif/link_side_model.sv
// Link-side source model: link clock, data-enable activity and key load
`timescale 1ns/10ps
`default_nettype none
module link_side_model #(
   parameter HALF = 16
) (
   input  wire logic clock,
   input  wire logic link_on,
   input  wire logic keys_good,
   output var  logic link_enable_in = 1'b0,
   output var  logic link_clock_seen = 1'b0,
   output var  logic key_load_done = 1'b0,
   output var  logic key_load_pass = 1'b0
);
   int cnt = 0;
   always @(posedge clock) begin
      cnt <= link_on ? cnt + 1 : 0;
      link_clock_seen <= link_on;
      link_enable_in <= link_on && (cnt % (2 * HALF) < HALF);
      key_load_done <= cnt > 8;
      // Result is garbage until done, so capture timing matters
      key_load_pass <= (cnt > 8) ? keys_good : ~key_load_pass;
   end
endmodule
`default_nettype wire

// ===== verif/video_output_control_regs_tb_top.sv
// Self-checking testbench for the video output control register bank
`timescale 1ns/10ps
`default_nettype none
module video_output_control_regs_tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        clock_en = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        power_down_pin = 1'b0;
   logic        enable_polarity = 1'b1;
   logic        idle_detect = 1'b0;
   logic        link_on = 1'b0;
   logic        keys_good = 1'b1;
   logic        link_enable_in, link_clock_seen, key_load_done, key_load_pass;
   logic [7:0]  reg_rdata;
   logic [1:0]  out_pin_mode;
   logic        primary_drive, secondary_drive, data_out_tristate, green_channel_sync_tristate;
   logic        power_down_active, low_power_active, protect_port_addr_lsb, mclk_external_sel;
   logic        embedded_timing_code_enable, force_internal_enable_gen, use_internal_enable;
   logic        data_enable_out, test_bit_ok;
   logic [2:0]  interlace_offset;
   logic [5:0]  vertical_start_delay;
   logic [9:0]  horizontal_start_delay;
   logic [11:0] active_width, active_height;
   int          err_total = 0;
   int          compares = 0;
   always #2.5 clock = ~clock;
   link_side_model #(.HALF(16)) far_end (.clock, .link_on, .keys_good, .link_enable_in,
      .link_clock_seen, .key_load_done, .key_load_pass);
   video_output_control_regs DUT (.clock, .rst, .clock_en, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .power_down_pin, .link_enable_in, .link_clock_seen,
      .key_load_done, .key_load_pass, .enable_polarity, .idle_detect, .out_pin_mode,
      .primary_drive, .secondary_drive, .data_out_tristate, .green_channel_sync_tristate,
      .power_down_active, .low_power_active, .protect_port_addr_lsb, .mclk_external_sel,
      .embedded_timing_code_enable, .force_internal_enable_gen, .use_internal_enable,
      .data_enable_out, .interlace_offset, .vertical_start_delay, .horizontal_start_delay,
      .active_width, .active_height, .test_bit_ok);
   //****************************************************************
   // Shared tasks
   //****************************************************************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(12'(d), 12'(exp));
   endtask
   //****************************************************************
   // Scenarios
   //****************************************************************
   task automatic t_defaults;
      logic [7:0] rv [11] = '{8'h02, 8'h08, 8'h80, 8'h01, 8'h04, 8'h05, 8'h00, 8'h02,
                              8'hd0, 8'h00, 8'h00};
      for (int i = 0; i < 11; i++) rd_chk(8'h25 + 8'(i), rv[i]);
      chk(active_width, 12'h500);
      chk(active_height, 12'h2d0);
      chk(12'(horizontal_start_delay), 12'h104);
      rd_chk(8'h30, 8'h00);
   endtask
   task automatic t_geometry;
      wr(8'h28, 8'hfe);
      wr(8'h29, 8'h5a);
      wr(8'h2a, 8'hfc);
      wr(8'h2b, 8'hab);
      wr(8'h2c, 8'hf3);
      wr(8'h2d, 8'h00);
      wr(8'h2e, 8'hff);
      settle(2);
      chk(12'(vertical_start_delay), 12'h03f);
      chk(12'(horizontal_start_delay), 12'h25a);
      chk(active_width, 12'hcab);
      chk(active_height, 12'h300);
      chk(12'(test_bit_ok), 12'h001);
      rd_chk(8'h2a, 8'h0c);
      rd_chk(8'h2e, 8'h80);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 3; m++) begin
         wr(8'h25, 8'(m * 4 + 3));
         settle(2);
         chk(12'(out_pin_mode), 12'(m));
         chk(12'(primary_drive), 12'h001);
         chk(12'(secondary_drive), 12'(m != 0));
      end
      wr(8'h26, 8'h88);
      settle(2);
      chk(12'(primary_drive), 12'h000);
      chk(12'(data_out_tristate), 12'h001);
      wr(8'h26, 8'h48);
      wr(8'h25, 8'h08);
      settle(2);
      chk(12'(green_channel_sync_tristate), 12'h001);
      chk(12'(data_out_tristate), 12'h000);
      chk(12'(primary_drive), 12'h000);
   endtask
   task automatic t_pin;
      for (int f = 0; f < 4; f++) begin
         wr(8'h26, 8'(8 + f * 2));
         power_down_pin <= 1'b1;
         settle(5);
         chk(12'(power_down_active), 12'(f < 2));
         chk(12'(data_out_tristate), 12'(f > 1));
         chk(12'(green_channel_sync_tristate), 12'(f % 2));
         @(posedge clock);
         power_down_pin <= 1'b0;
         settle(5);
         chk(12'(power_down_active), 12'h000);
      end
      wr(8'h26, 8'h00);
      settle(5);
      chk(12'(power_down_active), 12'h001);
   endtask
   task automatic t_ctrl;
      chk(12'(low_power_active), 12'h000);
      @(posedge clock);
      idle_detect <= 1'b1;
      wr(8'h27, 8'h7f);
      settle(2);
      chk(12'(low_power_active), 12'h000);
      chk(12'(protect_port_addr_lsb), 12'h001);
      chk(12'(mclk_external_sel), 12'h001);
      chk(12'(embedded_timing_code_enable), 12'h001);
      chk(12'(force_internal_enable_gen), 12'h001);
      chk(12'(interlace_offset), 12'h007);
      wr(8'h27, 8'h80);
      settle(2);
      chk(12'(low_power_active), 12'h001);
      chk(12'(mclk_external_sel), 12'h000);
      chk(12'(embedded_timing_code_enable), 12'h000);
   endtask
   // Write taken while the enable is low must leave the width lower register and active_width untouched
   task automatic t_freeze;
      @(posedge clock);
      clock_en <= 1'b0;
      wr(8'h2b, 8'h11);
      clock_en <= 1'b1;
      settle(2);
      chk(active_width, 12'hcab);
      rd_chk(8'h2b, 8'hab);
   endtask
   task automatic t_status;
      logic [7:0] d;
      @(posedge clock);
      link_on <= 1'b1;
      settle(600);
      rd(8'h2f, d);
      chk(12'(d & 8'hbf), 12'h02f);
      wr(8'h2f, 8'h00);
      wr(8'h27, 8'h08);
      rd(8'h2f, d);
      chk(12'(d & 8'hbf), 12'h02f);
      chk(12'(use_internal_enable), 12'h001);
      @(posedge clock);
      link_on <= 1'b0;
      settle(600);
      rd(8'h2f, d);
      chk(12'(d & 8'h67), 12'h000);
      chk(12'(data_enable_out), 12'h000);
      @(posedge clock);
      enable_polarity <= 1'b0;
      keys_good <= 1'b0;
      link_on <= 1'b1;
      settle(40);
      rd(8'h2f, d);
      chk(12'(d[3]), 12'h000);
      chk(12'(d[6]), 12'h001);
      @(posedge clock);
      link_on <= 1'b0;
      settle(8);
      chk(12'(data_enable_out), 12'h001);
   endtask
   task automatic complete_run;
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Nothing waits on a handshake, so one watchdog cuts any hang short
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_defaults();
      t_geometry();
      t_modes();
      t_pin();
      t_ctrl();
      t_freeze();
      t_status();
      complete_run();
   end
endmodule
`default_nettype wire
